/* spsim_pkg.sv */
// Package for the serial port status and interrupt mask block.
// Assumes a 32-bit APB with byte addressing; one register per aligned word.
package spsim_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_COMMAND  = 8'h00;
	localparam logic [7:0] OFF_IRQ_EN   = 8'h08;
	localparam logic [7:0] OFF_IRQ_DIS  = 8'h0C;
	localparam logic [7:0] OFF_MASK     = 8'h10;
	localparam logic [7:0] OFF_STATUS   = 8'h14;
	localparam logic [7:0] OFF_RX_HOLD  = 8'h18;
	localparam logic [7:0] OFF_TX_HOLD  = 8'h1C;
	localparam logic [7:0] OFF_IDLE_TOV = 8'h24;

	// Status and mask bit positions
	localparam int ST_RX_AVAIL  = 0;
	localparam int ST_TX_FREE   = 1;
	localparam int ST_BREAK     = 2;
	localparam int ST_RX_DMA_END = 3;
	localparam int ST_TX_DMA_END = 4;
	localparam int ST_OVERRUN   = 5;
	localparam int ST_FRAMING   = 6;
	localparam int ST_PARITY    = 7;
	localparam int ST_TIMEOUT   = 8;
	localparam int ST_TX_DRAINED = 9;
	localparam int ST_REPEAT    = 10;
	localparam int ST_TX_BUF_EMPTY = 11;
	localparam int ST_RX_BUF_FULL  = 12;
	localparam int ST_NAK       = 13;
	localparam int ST_CHG_LSB   = 16;
	localparam int ST_IMG_LSB   = 20;

	// Command register bit positions
	localparam int CMD_RX_ON      = 4;
	localparam int CMD_RX_OFF     = 5;
	localparam int CMD_TX_ON      = 6;
	localparam int CMD_TX_OFF     = 7;
	localparam int CMD_CLR_STATUS = 8;
	localparam int CMD_BREAK      = 9;
	localparam int CMD_ARM_IDLE   = 11;
	localparam int CMD_CLR_REPEAT = 10;
	localparam int CMD_CLR_NAK    = 14;

	// Widths, valid bits and values after reset
	localparam int MASK_W = 20;
	localparam int TOV_W  = 16;
	localparam int CHR_W  = 9;
	localparam logic [MASK_W-1:0] MASK_VALID = 20'hF3FFF;
	localparam logic [MASK_W-1:0] MASK_RST   = 20'h00000;
	localparam logic [TOV_W-1:0]  TOV_RST    = 16'h0000;

	// Receiver events from the character engine
	typedef struct packed {
		logic             char_done;
		logic [CHR_W-1:0] char_data;
		logic             busy;
		logic             break_evt;
		logic             stop_low;
		logic             parity_fail;
		logic             bit_tick;
	} spsim_rx_evt_t;

	// Transmitter state from the shifter
	typedef struct packed {
		logic shift_take;
		logic shift_busy;
		logic break_started;
		logic repeat_limit;
		logic nak_seen;
	} spsim_tx_evt_t;

	// Live signals of the peripheral DMA channels
	typedef struct packed {
		logic rx_dma_transfer_done;
		logic tx_dma_transfer_done;
		logic tx_dma_buffer_empty;
		logic rx_dma_buffer_full;
	} spsim_dma_t;

	// Modem inputs, bit 0 ring, 1 set ready, 2 carrier, 3 clear to send
	typedef logic [3:0] spsim_modem_t;

endpackage

/* spsim_core.sv */
// Status flags, interrupt mask and APB register file of a serial port.
// Assumes character engines outside deliver one-cycle event pulses on SYS_CLK.
//
// Behaviour
// - mask view register shows per-source interrupt permission, same bits as status bits 0-19; image bits 20-23 have no mask.
// - rx char available sets on full character, clears on holding read or disable.
// - char in progress at rx disable makes rx ready 1 on re-enable.
// - tx free is 0 while char pending, break pending or disabled.
// - tx free reads 1 only while enabled with no character or break waiting in tx holding.
// - break flag latches break or break end until clear status.
// - bit 3 shows live rx DMA transfer done.
// - bit 4 shows live tx DMA transfer done.
// - overrun flag sets on overrun, holds until clear status.
// - framing flag sets on low stop bit, holds until clear status.
// - parity flag sets on parity fail, holds until clear status.
// - timeout flag sets after armed timer expires; zero while value zero.
// - tx drained is 1 only with holding and shifter empty; 0 disabled.
// - repeat limit flag latches until clear repeat limit command.
// - bit 11 shows live tx DMA buffer empty.
// - bit 12 shows live rx DMA buffer full.
// - nak flag latches until clear nak command.
// - modem line change flags bits 16-19; status read clears them.
// - bits 20-23 show present modem input levels.
// - enable write sets mask bits, disable write clears, zeros ignored.
// - carrier image reads 1 high, 0 low.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ns
module spsim_core
	import spsim_pkg::*;
(
	input  wire logic          SYS_CLK,
	input  wire logic          RST,
	input  wire logic          PSEL,
	input  wire logic          PENABLE,
	input  wire logic          PWRITE,
	input  wire logic [7:0]    PADDR,
	input  wire logic [31:0]   PWDATA,
	output logic               PREADY,
	output logic [31:0]        PRDATA,
	output logic               PSLVERR,
	input  wire spsim_rx_evt_t RX_EVT,
	input  wire spsim_tx_evt_t TX_EVT,
	input  wire spsim_dma_t    DMA,
	input  wire spsim_modem_t  MODEM,
	output logic               RX_ENABLE,
	output logic               TX_ENABLE,
	output logic               TX_CHAR_VALID,
	output logic [CHR_W-1:0]   TX_CHAR_DATA,
	output logic               BREAK_REQ,
	output logic               IRQ
);

	// Sticky flag: a set in the clearing cycle wins
	function automatic logic sticky(input logic q, input logic set, input logic clr);
		sticky = set | (q & ~clr);
	endfunction

	logic                 pready_reg;
	logic [31:0]          prdata_reg;
	logic                 pslverr_reg;
	logic [MASK_W-1:0]    mask_reg;
	logic [TOV_W-1:0]     tov_reg;
	logic [TOV_W-1:0]     tcnt_reg;
	logic                 tarmed_reg;
	logic                 rx_en_reg;
	logic                 tx_en_reg;
	logic                 resume_reg;
	logic                 rx_avail_reg;
	logic [CHR_W-1:0]     rx_data_reg;
	logic                 rx_keep_reg;
	logic                 tx_pend_reg;
	logic [CHR_W-1:0]     tx_data_reg;
	logic                 brk_pend_reg;
	logic                 brk_reg;
	logic                 ovr_reg;
	logic                 frm_reg;
	logic                 par_reg;
	logic                 tmo_reg;
	logic                 rep_reg;
	logic                 nak_reg;
	logic [3:0]           chg_reg;
	logic [3:0]           chg_snap_reg;
	logic [3:0]           modem_prev_reg;
	logic                 primed_reg;
	logic                 irq_reg;
	logic [31:0]          stat_vec;

	// APB phase and address decode
	wire setup_ph  = PSEL & ~PENABLE;
	wire access_ok = PSEL & PENABLE & pready_reg;
	wire wr_acc    = access_ok & PWRITE;
	wire rd_acc    = access_ok & ~PWRITE;
	wire hit_cmd   = (PADDR == OFF_COMMAND);
	wire hit_ien   = (PADDR == OFF_IRQ_EN);
	wire hit_idis  = (PADDR == OFF_IRQ_DIS);
	wire hit_mask  = (PADDR == OFF_MASK);
	wire hit_stat  = (PADDR == OFF_STATUS);
	wire hit_rxh   = (PADDR == OFF_RX_HOLD);
	wire hit_txh   = (PADDR == OFF_TX_HOLD);
	wire hit_tov   = (PADDR == OFF_IDLE_TOV);
	wire mapped    = hit_cmd | hit_ien | hit_idis | hit_mask | hit_stat | hit_rxh | hit_txh
		| hit_tov;

	// Commands, only on a write access phase
	wire cmd_wr     = wr_acc & hit_cmd;
	wire rx_on      = cmd_wr & PWDATA[CMD_RX_ON];
	wire rx_off     = cmd_wr & PWDATA[CMD_RX_OFF];
	wire tx_on      = cmd_wr & PWDATA[CMD_TX_ON];
	wire tx_off     = cmd_wr & PWDATA[CMD_TX_OFF];
	wire clr_status = cmd_wr & PWDATA[CMD_CLR_STATUS];
	wire begin_brk  = cmd_wr & PWDATA[CMD_BREAK];
	wire arm_idle   = cmd_wr & PWDATA[CMD_ARM_IDLE];
	wire clr_repeat = cmd_wr & PWDATA[CMD_CLR_REPEAT];
	wire clr_nak    = cmd_wr & PWDATA[CMD_CLR_NAK];

	// Enables: disable wins when both bits are written together
	wire rx_en_next = ~rx_off & (rx_on | rx_en_reg);
	wire tx_en_next = ~tx_off & (tx_on | tx_en_reg);

	// Received characters only count while the receiver runs
	wire char_in    = RX_EVT.char_done & rx_en_reg;
	wire rxh_read   = rd_acc & hit_rxh & ~rx_keep_reg;
	wire overrun    = char_in & rx_avail_reg & ~rxh_read;
	wire resume_set = resume_reg & rx_on & ~rx_en_reg;

	// Transmit side
	wire txh_write  = wr_acc & hit_txh & tx_en_reg;
	wire tx_free    = tx_en_reg & ~tx_pend_reg & ~brk_pend_reg;
	wire tx_drained = tx_en_reg & ~tx_pend_reg & ~TX_EVT.shift_busy;

	// Idle timer expires on the last bit tick of an armed count
	wire tmo_zero   = (tov_reg == TOV_RST);
	wire tmo_expire = tarmed_reg & RX_EVT.bit_tick & (tcnt_reg == 16'h0001);

	// Modem change detect, quiet until the first sample is taken
	wire [3:0] modem_chg = {4{primed_reg}} & (MODEM ^ modem_prev_reg);
	wire stat_read  = rd_acc & hit_stat;

	// Status image assembly
	always_comb begin
		stat_vec                    = 32'h00000000;
		stat_vec[ST_RX_AVAIL]       = rx_avail_reg;
		stat_vec[ST_TX_FREE]        = tx_free;
		stat_vec[ST_BREAK]          = brk_reg;
		stat_vec[ST_RX_DMA_END]     = DMA.rx_dma_transfer_done;
		stat_vec[ST_TX_DMA_END]     = DMA.tx_dma_transfer_done;
		stat_vec[ST_OVERRUN]        = ovr_reg;
		stat_vec[ST_FRAMING]        = frm_reg;
		stat_vec[ST_PARITY]         = par_reg;
		stat_vec[ST_TIMEOUT]        = tmo_reg;
		stat_vec[ST_TX_DRAINED]     = tx_drained;
		stat_vec[ST_REPEAT]         = rep_reg;
		stat_vec[ST_TX_BUF_EMPTY]   = DMA.tx_dma_buffer_empty;
		stat_vec[ST_RX_BUF_FULL]    = DMA.rx_dma_buffer_full;
		stat_vec[ST_NAK]            = nak_reg;
		stat_vec[ST_CHG_LSB+:4]     = chg_reg;
		stat_vec[ST_IMG_LSB+:4]     = MODEM;
	end

	// Read mux, sampled in the setup cycle
	wire [31:0] rd_mux =
		hit_stat ? stat_vec :
		hit_mask ? {12'h000, mask_reg} :
		hit_rxh  ? {23'h000000, rx_data_reg} :
		hit_tov  ? {16'h0000, tov_reg} : 32'h00000000;

	// APB slave: one wait-free access phase, answer from flops
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= setup_ph;
			prdata_reg  <= (setup_ph & ~PWRITE) ? rd_mux : 32'h00000000;
			pslverr_reg <= setup_ph & ~mapped;
		end
	end

	// Mask and timer value registers
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			mask_reg <= MASK_RST;
			tov_reg  <= TOV_RST;
		end else begin
			if (wr_acc & hit_ien)
				mask_reg <= mask_reg | (PWDATA[MASK_W-1:0] & MASK_VALID);
			else if (wr_acc & hit_idis)
				mask_reg <= mask_reg & ~PWDATA[MASK_W-1:0];
			if (wr_acc & hit_tov)
				tov_reg <= PWDATA[TOV_W-1:0];
		end
	end

	// Enables and the resume marker for a character cut short
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rx_en_reg  <= 1'b0;
			tx_en_reg  <= 1'b0;
			resume_reg <= 1'b0;
		end else begin
			rx_en_reg  <= rx_en_next;
			tx_en_reg  <= tx_en_next;
			if (rx_off & rx_en_reg)
				resume_reg <= RX_EVT.busy;
			else if (rx_on)
				resume_reg <= 1'b0;
		end
	end

	// Receive holding; a char landing in the read setup cycle keeps its flag
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rx_avail_reg <= 1'b0;
			rx_data_reg  <= '0;
			rx_keep_reg  <= 1'b0;
		end else begin
			rx_keep_reg <= setup_ph & ~PWRITE & hit_rxh & char_in;
			if (char_in)
				rx_data_reg <= RX_EVT.char_data;
			// set on char, clear on read or off
			rx_avail_reg <= (rx_en_next | resume_set)
				& sticky(rx_avail_reg, char_in | resume_set, rxh_read);
		end
	end

	// Transmit holding and break request; disabling drops both
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			tx_pend_reg  <= 1'b0;
			tx_data_reg  <= '0;
			brk_pend_reg <= 1'b0;
		end else begin
			if (txh_write)
				tx_data_reg <= PWDATA[CHR_W-1:0];
			tx_pend_reg  <= tx_en_next & sticky(tx_pend_reg, txh_write, TX_EVT.shift_take);
			brk_pend_reg <= tx_en_next & sticky(brk_pend_reg, begin_brk & tx_en_reg,
				TX_EVT.break_started);
		end
	end

	// Sticky error flags with their clearing commands, and the interrupt
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			irq_reg <= 1'b0;
			brk_reg <= 1'b0;
			ovr_reg <= 1'b0;
			frm_reg <= 1'b0;
			par_reg <= 1'b0;
			rep_reg <= 1'b0;
			nak_reg <= 1'b0;
		end else begin
			brk_reg <= sticky(brk_reg, RX_EVT.break_evt, clr_status);
			ovr_reg <= sticky(ovr_reg, overrun, clr_status);
			frm_reg <= sticky(frm_reg, RX_EVT.stop_low, clr_status);
			par_reg <= sticky(par_reg, RX_EVT.parity_fail, clr_status);
			rep_reg <= sticky(rep_reg, TX_EVT.repeat_limit, clr_repeat);
			nak_reg <= sticky(nak_reg, TX_EVT.nak_seen, clr_nak);
			irq_reg <= |(stat_vec[MASK_W-1:0] & mask_reg);
		end
	end

	// Idle timer, counted in bit periods from the arm command
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			tcnt_reg   <= TOV_RST;
			tarmed_reg <= 1'b0;
			tmo_reg    <= 1'b0;
		end else begin
			if (arm_idle) begin
				tcnt_reg   <= tov_reg;
				tarmed_reg <= ~tmo_zero;
			end else if (tmo_expire)
				tarmed_reg <= 1'b0;
			else if (tarmed_reg & RX_EVT.bit_tick)
				tcnt_reg <= tcnt_reg - 16'h0001;
			// expiry sets, zero value forces low
			tmo_reg <= ~tmo_zero & sticky(tmo_reg, tmo_expire, arm_idle);
		end
	end

	// Modem change flags; a read clears only what it reported
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			chg_reg        <= 4'h0;
			chg_snap_reg   <= 4'h0;
			modem_prev_reg <= 4'h0;
			primed_reg     <= 1'b0;
		end else begin
			modem_prev_reg <= MODEM;
			primed_reg     <= 1'b1;
			chg_snap_reg   <= (setup_ph & ~PWRITE & hit_stat) ? chg_reg : 4'h0;
			chg_reg <= modem_chg | (chg_reg & ~({4{stat_read}} & chg_snap_reg));
		end
	end

	assign PREADY        = pready_reg;
	assign PRDATA        = prdata_reg;
	assign PSLVERR       = pslverr_reg;
	assign RX_ENABLE     = rx_en_reg;
	assign TX_ENABLE     = tx_en_reg;
	assign TX_CHAR_VALID = tx_pend_reg;
	assign TX_CHAR_DATA  = tx_data_reg;
	assign BREAK_REQ     = brk_pend_reg;
	assign IRQ           = irq_reg;

	mask_view_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		setup_ph & ~PWRITE & hit_mask |=> PRDATA == {12'h000, $past(mask_reg)})
		else $error("mask view read mismatch");
	rx_avail_set_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		char_in & ~rx_off |=> rx_avail_reg)
		else $error("rx ready not set by character");
	rx_resume_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		resume_reg & rx_on & ~rx_off & ~rx_en_reg |=> rx_avail_reg)
		else $error("rx ready not forced on re-enable");
	tx_free_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		txh_write & ~tx_off |=> ~stat_vec[ST_TX_FREE] && TX_CHAR_VALID)
		else $error("tx free high with char pending");
	break_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		brk_reg & ~clr_status |=> brk_reg)
		else $error("break flag lost without clear");
	dma_live_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		setup_ph & ~PWRITE & hit_stat
		|=> PRDATA[ST_RX_DMA_END] == $past(DMA.rx_dma_transfer_done))
		else $error("dma live bit missing from status read");
	tmo_zero_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		$past(tmo_zero) & tmo_zero |-> ~tmo_reg)
		else $error("timeout set with zero value");
	drained_off_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		~tx_en_reg |-> ~stat_vec[ST_TX_DRAINED] && ~stat_vec[ST_TX_FREE])
		else $error("tx status high while disabled");
	modem_chg_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		primed_reg && MODEM[3] != $past(MODEM[3]) |=> chg_reg[3])
		else $error("modem change not flagged");
	mask_en_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		wr_acc & hit_ien & PWDATA[ST_NAK] |=> mask_reg[ST_NAK])
		else $error("enable write did not set mask");
	irq_out_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(tx_free & mask_reg[ST_TX_FREE]) | (rx_avail_reg & mask_reg[ST_RX_AVAIL]) |=> IRQ)
		else $error("interrupt not raised");

endmodule

/* spsim_peer.sv */
// Behavioural far side: serial engine events, DMA channel levels, modem lines.
// Assumes its tasks are called just after a rising edge of SYS_CLK.
`timescale 1ns/1ns
module spsim_peer
	import spsim_pkg::*;
(
	input  wire logic     SYS_CLK,
	output spsim_rx_evt_t RX_EVT,
	output spsim_tx_evt_t TX_EVT,
	output spsim_dma_t    DMA,
	output spsim_modem_t  MODEM
);
	// Quiet lines before the first call
	initial begin
		RX_EVT = '0;
		TX_EVT = '0;
		DMA    = '0;
		MODEM  = '0;
	end

	// One-cycle event; data is inverted afterwards so stale data never matches
	task automatic rx_pulse(input spsim_rx_evt_t e);
		RX_EVT <= e;
		@(posedge SYS_CLK);
		RX_EVT <= '{char_data: ~e.char_data, busy: e.busy, default: 1'b0};
		@(posedge SYS_CLK);
	endtask

	// One-cycle event; the shifter busy level is kept
	task automatic tx_pulse(input spsim_tx_evt_t e);
		TX_EVT <= e;
		@(posedge SYS_CLK);
		TX_EVT <= '{shift_busy: e.shift_busy, default: 1'b0};
		@(posedge SYS_CLK);
	endtask

	// Levels change together at one edge
	task automatic set_lines(input logic [3:0] d, input logic [3:0] m);
		DMA   <= d;
		MODEM <= m;
		@(posedge SYS_CLK);
	endtask
endmodule

/* spsim_core_tb.sv */
// Self-checking bench for the serial port status and mask block.
// Assumes an APB master bench, the behavioural peer, one 125 MHz clock.
`timescale 1ns/1ns
`define CHK(got, exp) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
	end \
end
module spsim_core_tb
	import spsim_pkg::*;
;
	logic             sys_clk = 1'b0;
	logic             rst = 1'b1;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [7:0]       paddr = 8'h00;
	logic [31:0]      pwdata = 32'h00000000;
	logic             pready;
	logic [31:0]      prdata;
	logic             pslverr;
	logic             rx_enable;
	logic             tx_enable;
	logic             tx_char_valid;
	logic [CHR_W-1:0] tx_char_data;
	logic             break_req;
	logic             irq;
	spsim_rx_evt_t    rx_evt;
	spsim_tx_evt_t    tx_evt;
	spsim_dma_t       dma;
	spsim_modem_t     modem;
	logic [31:0]      rd;
	logic             err;
	int               failures = 0;
	int               samples_checked = 0;
	int               dma_pos [4] = '{12, 11, 4, 3};

	// Free-running system clock
	always #4 sys_clk = ~sys_clk;

	spsim_core dut (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
		.PRDATA(prdata), .PSLVERR(pslverr), .RX_EVT(rx_evt), .TX_EVT(tx_evt),
		.DMA(dma), .MODEM(modem), .RX_ENABLE(rx_enable), .TX_ENABLE(tx_enable),
		.TX_CHAR_VALID(tx_char_valid), .TX_CHAR_DATA(tx_char_data),
		.BREAK_REQ(break_req), .IRQ(irq));

	spsim_peer peer (.SYS_CLK(sys_clk), .RX_EVT(rx_evt), .TX_EVT(tx_evt), .DMA(dma),
		.MODEM(modem));

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		// Only the watchdog ends a wait that never sees pready
		while (pready !== 1'b1)
			@(posedge sys_clk);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// Only the bits under m are compared
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		`CHK(rd & m, e)
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		tick(5);
		rst <= 1'b0;
		tick(1);
		rchk(OFF_MASK, 32'hFFFFFFFF, 32'h00000000);
		rchk(OFF_STATUS, 32'h00000203, 32'h00000000);
		wr(OFF_IRQ_EN, 32'hFFFFFFFF);
		rchk(OFF_MASK, 32'hFFFFFFFF, {12'h000, MASK_VALID});
		wr(OFF_IRQ_DIS, 32'h00000F00);
		wr(OFF_IRQ_EN, 32'h00000000);
		rchk(OFF_MASK, 32'hFFFFFFFF, 32'h000F30FF);
		wr(OFF_IRQ_DIS, 32'hFFFFFFFF);
		rchk(OFF_MASK, 32'hFFFFFFFF, 32'h00000000);
		apb(1'b0, 8'h04, 32'h00000000);
		`CHK({err, rd}, 33'h100000000)
		$display("test registers done");
		wr(OFF_COMMAND, 32'h00000040);
		`CHK(tx_enable, 1'b1)
		rchk(OFF_STATUS, 32'h00000202, 32'h00000202);
		wr(OFF_IRQ_EN, 32'h00000002);
		tick(1);
		`CHK(irq, 1'b1)
		wr(OFF_TX_HOLD, 32'h000001A5);
		`CHK({tx_char_valid, tx_char_data}, 10'h3A5)
		rchk(OFF_STATUS, 32'h00000202, 32'h00000000);
		`CHK(irq, 1'b0)
		peer.tx_pulse('{shift_take: 1'b1, shift_busy: 1'b1, default: 1'b0});
		rchk(OFF_STATUS, 32'h00000202, 32'h00000002);
		peer.tx_pulse('{default: 1'b0});
		rchk(OFF_STATUS, 32'h00000202, 32'h00000202);
		wr(OFF_COMMAND, 32'h00000200);
		`CHK(break_req, 1'b1)
		rchk(OFF_STATUS, 32'h00000002, 32'h00000000);
		peer.tx_pulse('{break_started: 1'b1, default: 1'b0});
		`CHK(break_req, 1'b0)
		rchk(OFF_STATUS, 32'h00000002, 32'h00000002);
		wr(OFF_COMMAND, 32'h00000080);
		`CHK(tx_enable, 1'b0)
		rchk(OFF_STATUS, 32'h00000202, 32'h00000000);
		wr(OFF_COMMAND, 32'h00000040);
		rchk(OFF_STATUS, 32'h00000002, 32'h00000002);
		wr(OFF_IRQ_DIS, 32'hFFFFFFFF);
		$display("test transmitter done");
		wr(OFF_COMMAND, 32'h00000010);
		`CHK(rx_enable, 1'b1)
		peer.rx_pulse('{char_done: 1'b1, char_data: 9'h0C3, default: 1'b0});
		rchk(OFF_STATUS, 32'h00000001, 32'h00000001);
		rchk(OFF_RX_HOLD, 32'h000001FF, 32'h000000C3);
		rchk(OFF_STATUS, 32'h00000001, 32'h00000000);
		peer.rx_pulse('{char_done: 1'b1, char_data: 9'h011, default: 1'b0});
		peer.rx_pulse('{char_done: 1'b1, char_data: 9'h122, default: 1'b0});
		peer.rx_pulse('{break_evt: 1'b1, stop_low: 1'b1, parity_fail: 1'b1, default: 1'b0});
		rchk(OFF_STATUS, 32'h000000E5, 32'h000000E5);
		wr(OFF_COMMAND, 32'h00000100);
		rchk(OFF_STATUS, 32'h000000E5, 32'h00000001);
		wr(OFF_COMMAND, 32'h00000020);
		`CHK(rx_enable, 1'b0)
		rchk(OFF_STATUS, 32'h00000001, 32'h00000000);
		wr(OFF_COMMAND, 32'h00000010);
		rchk(OFF_STATUS, 32'h00000001, 32'h00000000);
		peer.rx_pulse('{busy: 1'b1, default: 1'b0});
		wr(OFF_COMMAND, 32'h00000020);
		peer.rx_pulse('{default: 1'b0});
		wr(OFF_COMMAND, 32'h00000010);
		rchk(OFF_STATUS, 32'h00000001, 32'h00000001);
		$display("test receiver done");
		peer.tx_pulse('{repeat_limit: 1'b1, nak_seen: 1'b1, default: 1'b0});
		wr(OFF_COMMAND, 32'h00000100);
		rchk(OFF_STATUS, 32'h00002400, 32'h00002400);
		wr(OFF_COMMAND, 32'h00000400);
		rchk(OFF_STATUS, 32'h00002400, 32'h00002000);
		wr(OFF_COMMAND, 32'h00004000);
		rchk(OFF_STATUS, 32'h00002400, 32'h00000000);
		$display("test smart card flags done");
		wr(OFF_IDLE_TOV, 32'h00000003);
		wr(OFF_COMMAND, 32'h00000800);
		repeat (2) peer.rx_pulse('{bit_tick: 1'b1, default: 1'b0});
		rchk(OFF_STATUS, 32'h00000100, 32'h00000000);
		peer.rx_pulse('{bit_tick: 1'b1, default: 1'b0});
		rchk(OFF_STATUS, 32'h00000100, 32'h00000100);
		wr(OFF_IDLE_TOV, 32'h00000000);
		wr(OFF_COMMAND, 32'h00000800);
		repeat (4) peer.rx_pulse('{bit_tick: 1'b1, default: 1'b0});
		rchk(OFF_STATUS, 32'h00000100, 32'h00000000);
		$display("test idle timer done");
		for (int i = 0; i < 4; i++) begin
			peer.set_lines(4'(1 << i), 4'h0);
			rchk(OFF_STATUS, 32'h00001818, 32'h00000001 << dma_pos[i]);
		end
		peer.set_lines(4'h0, 4'h0);
		rchk(OFF_STATUS, 32'h00001818, 32'h00000000);
		$display("test dma levels done");
		peer.set_lines(4'h0, 4'h5);
		rchk(OFF_STATUS, 32'h00FF0000, 32'h00550000);
		rchk(OFF_STATUS, 32'h00FF0000, 32'h00500000);
		peer.set_lines(4'h0, 4'hF);
		rchk(OFF_STATUS, 32'h00FF0000, 32'h00FA0000);
		$display("test modem lines done");
		conclude();
	end

	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		failures++;
		conclude();
	end
endmodule
